// ### rtl/ssf_filter.sv
// Purpose: persistence filter for a comparator level
// Assumes: input already synchronised
// Notes: output follows input only after it held steady for CYC cycles
`timescale 1ns/1ps
module ssf_filter #(
  parameter int unsigned CYC = 50
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic clear_i,
  input wire logic level_i,
  output logic level_o
);
  import ssf_pkg::*;

  localparam int unsigned W = $clog2(CYC + 1);
  localparam logic [W-1:0] LAST = W'(CYC - 1);

  logic [W-1:0] cnt_q;

  // count while input differs from output; a glitch restarts the wait
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_q <= '0;
      level_o <= 1'b0;
    end
    else if (clear_i)
    begin
      cnt_q <= '0;
      level_o <= 1'b0;
    end
    else if (level_i == level_o)
      cnt_q <= '0;
    else if (cnt_q == LAST)
    begin
      cnt_q <= '0;
      level_o <= level_i;
    end
    else
      cnt_q <= cnt_q + W'(1);
  end
endmodule

// ### rtl/ssf_pkg.sv
// Purpose: types shared by the sequencer modules
// Assumes: nothing beyond the header
// Notes: one-hot switching states
package ssf_pkg;

  // switching state machine, one-hot
  typedef enum logic [5:0] {
    SSF_OFF         = 6'b00_0001,
    SSF_WAIT_HS_OFF = 6'b00_0010,
    SSF_LS_ON       = 6'b00_0100,
    SSF_WAIT_LS_OFF = 6'b00_1000,
    SSF_HS_ON       = 6'b01_0000,
    SSF_OV_HOLD     = 6'b10_0000
  } ssf_state_t;

  // current-limit source scale during soft-start
  typedef enum logic [1:0] {
    SSF_CURRENT_LIMIT_SOURCE_25  = 2'h0,
    SSF_CURRENT_LIMIT_SOURCE_50  = 2'h1,
    SSF_CURRENT_LIMIT_SOURCE_75  = 2'h2,
    SSF_CURRENT_LIMIT_SOURCE_100 = 2'h3
  } ssf_current_limit_source_t;

endpackage

// ### rtl/ssf_regs.svh
// Purpose: timing counts and fixed figures of the start-up and fault sequencer
// Assumes: 10 MHz system clock
// Notes: least times round up, longest times round down, never below one cycle
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH

`define SSF_CLK_MHZ 10
// undervoltage, overvoltage and power-good filter delay
`define SSF_FILT_NS 5000
`define SSF_FILT_CYC ((`SSF_FILT_NS * `SSF_CLK_MHZ + 999) / 1000)
// normal minimum off-time, a least time
`define SSF_MIN_OFF_NS 400
`define SSF_MIN_OFF_CYC ((`SSF_MIN_OFF_NS * `SSF_CLK_MHZ + 999) / 1000)
// upper bound on the off one-shot; the normal value must stay within it
`define SSF_MAX_OFF_NS 550
`define SSF_MAX_OFF_CYC ((`SSF_MAX_OFF_NS * `SSF_CLK_MHZ) / 1000)
// soft-start: four steps of 110 switching cycles
`define SSF_SS_STEP 110
`define SSF_SS_STEPS 4
`define SSF_SS_TOTAL (`SSF_SS_STEP * `SSF_SS_STEPS)
`define SSF_SS_W 9
// level offset applied to the sensed output during the first step
`define SSF_SENSED_OUTPUT_LEVEL_OFFSET_MV 120
// number of comparator levels entering through the pin synchroniser
`define SSF_NSENSE 13

`endif

// ### rtl/ssf_sense_if.sv
// Purpose: carries synchronised comparator levels into the sequencer core
// Assumes: single clock domain
// Notes: the synchroniser drives, the core only reads
`timescale 1ns/1ps
interface ssf_sense_if;
  logic supply_por;
  logic supply_hi;
  logic supply_lo;
  logic en_high;
  logic en_low;
  logic uv_cmp;
  logic ov_cmp;
  logic pg_cmp;
  logic dl_off;
  logic phase_low;
  logic phase_strong;
  logic ton_req;
  logic ton_done;
  modport src (output supply_por, supply_hi, supply_lo, en_high, en_low, uv_cmp, ov_cmp,
               pg_cmp, dl_off, phase_low, phase_strong, ton_req, ton_done);
  modport dst (input supply_por, supply_hi, supply_lo, en_high, en_low, uv_cmp, ov_cmp,
               pg_cmp, dl_off, phase_low, phase_strong, ton_req, ton_done);
endinterface

// ### rtl/ssf_seq.sv
// Purpose: start-up, lockout, soft-start, fault latch and gate-drive interlock of one buck channel
// Assumes: analog comparators report levels; gate drivers and switches are outside
// Notes: pin levels pass the three-stage synchroniser, so interlock waits include its latency
// What this block does
// - output 30% low latches both drives high-impedance and controller off
// - undervoltage must persist about 5 us before the fault latches
// - faults clear only by toggling supply or enable pin
// - supply above 3 V releases internal power-on reset
// - below 4.2 V inhibited; crossing up clears faults and soft-start
// - first switching action is a low-side pulse charging the boost cap
// - soft-start limits current-limit source over 440 switching cycles
// - first 110 cycles: quarter limit, doubled off-time, 120 mV offset
// - next steps: half, three quarters, full limit, normal off-time
// - undervoltage and power-good evaluation only after soft-start completes
// - 100 mV hysteresis; at 4.1 V both drives go high-impedance
// - high-side drive waits until low-side drive seen below 1 V
// - low-side drive waits until phase node seen below 1 V
// - high side starts weak, strong pull-up added at 1.5 V
// - every on pulse followed by a minimum off one-shot, at most 550 ns except 800 ns in the first step
// - enable pin high: power save; floating: no power save; low: off
// - power-good held low until soft-start done and output reaches 90%
// - overvoltage latches low-side on and controller off until reset
// - normal minimum off-time is 400 ns
`timescale 1ns/1ps
`include "ssf_regs.svh"
module ssf_seq (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic supply_por_cmp_i,
  input wire logic supply_rise_cmp_i,
  input wire logic supply_fall_cmp_i,
  input wire logic enable_powersave_pin_high_i,
  input wire logic enable_powersave_pin_low_i,
  input wire logic sensed_output_uv_cmp_i,
  input wire logic sensed_output_ov_cmp_i,
  input wire logic sensed_output_pg_cmp_i,
  input wire logic low_side_drive_off_i,
  input wire logic phase_node_low_i,
  input wire logic phase_node_strong_i,
  input wire logic on_request_i,
  input wire logic on_time_done_i,
  output logic high_side_drive_o,
  output logic high_side_drive_strong_o,
  output logic high_side_drive_oe_o,
  output logic low_side_drive_o,
  output logic low_side_drive_oe_o,
  output ssf_pkg::ssf_current_limit_source_t current_limit_source_o,
  output logic sensed_output_level_offset_en_o,
  output logic powersave_en_o,
  output logic power_good_out_oe_o,
  output logic power_good_o,
  output logic uv_fault_o,
  output logic ov_fault_o,
  output logic softstart_done_o
);
  import ssf_pkg::*;

  localparam logic [`SSF_SS_W-1:0] SS_STEP = `SSF_SS_W'(`SSF_SS_STEP);
  localparam logic [`SSF_SS_W-1:0] SS_TOTAL = `SSF_SS_W'(`SSF_SS_TOTAL);
  localparam logic [3:0] OFF_NORM = 4'(`SSF_MIN_OFF_CYC);
  localparam logic [3:0] OFF_DBL = 4'(2 * `SSF_MIN_OFF_CYC);

  ssf_sense_if sense ();

  logic uv_filt;
  logic ov_filt;
  logic pg_filt;
  logic lockout_q;
  logic uv_fault_q;
  logic ov_fault_q;
  logic [`SSF_SS_W-1:0] ss_cnt_q;
  logic [3:0] off_cnt_q;
  ssf_state_t state_q;
  ssf_state_t state_d;
  logic en_on;
  logic restart;
  logic ss_done;
  logic eval_en;
  logic drive_en;
  logic cycle_done;
  logic first_step;
  ssf_current_limit_source_t current_limit_source_step;

  // comparator levels cross into the clock domain here
  ssf_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .raw_i     ({supply_por_cmp_i, supply_rise_cmp_i, supply_fall_cmp_i,
                 enable_powersave_pin_high_i, enable_powersave_pin_low_i,
                 sensed_output_uv_cmp_i, sensed_output_ov_cmp_i, sensed_output_pg_cmp_i,
                 low_side_drive_off_i, phase_node_low_i, phase_node_strong_i,
                 on_request_i, on_time_done_i}),
    .sense     (sense)
  );

  // pin modes
  // floating pin reads neither high nor low and still enables
  assign en_on = !sense.en_low;

  // lockout exit restart
  // restart holds while supply is low, por is out or the pin is low
  assign restart = !sense.supply_por || lockout_q || !en_on;

  assign ss_done = (ss_cnt_q == SS_TOTAL);
  assign first_step = (ss_cnt_q < SS_STEP);

  assign eval_en = ss_done && !restart;

  ssf_filter #(.CYC(`SSF_FILT_CYC)) u_uv_filt (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .clear_i   (!eval_en),
    .level_i   (sense.uv_cmp),
    .level_o   (uv_filt)
  );

  // overvoltage filter, active from start-up on
  ssf_filter #(.CYC(`SSF_FILT_CYC)) u_ov_filt (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .clear_i   (restart),
    .level_i   (sense.ov_cmp),
    .level_o   (ov_filt)
  );

  ssf_filter #(.CYC(`SSF_FILT_CYC)) u_pg_filt (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .clear_i   (!eval_en),
    .level_i   (sense.pg_cmp),
    .level_o   (pg_filt)
  );

  // por holds lockout
  // set at the falling threshold, released only above the rising one
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      lockout_q <= 1'b1;
    else if (!sense.supply_por || !sense.supply_lo)
      lockout_q <= 1'b1;
    else if (sense.supply_hi)
      lockout_q <= 1'b0;
  end

  // undervoltage latch
  // set wins over the clear so a late event is never lost
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      uv_fault_q <= 1'b0;
    else if (uv_filt)
      uv_fault_q <= 1'b1;
    else if (restart)
      uv_fault_q <= 1'b0;
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ov_fault_q <= 1'b0;
    else if (ov_filt)
      ov_fault_q <= 1'b1;
    else if (restart)
      ov_fault_q <= 1'b0;
  end

  // controller latched off
  // drives float on lockout, pin low or undervoltage; overvoltage keeps them driven
  assign drive_en = !restart && !uv_fault_q;

  // a cycle completes when the on pulse ends
  assign cycle_done = (state_q == SSF_HS_ON) && sense.ton_done;

  // 440-cycle span
  // saturates at 440 so the limit stays at 100% afterwards
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ss_cnt_q <= '0;
    else if (restart)
      ss_cnt_q <= '0;
    else if (cycle_done && !ss_done)
      ss_cnt_q <= ss_cnt_q + `SSF_SS_W'(1);
  end

  always_comb
  begin
    if (first_step)
      current_limit_source_step = SSF_CURRENT_LIMIT_SOURCE_25;
    else if (ss_cnt_q < 2 * SS_STEP)
      current_limit_source_step = SSF_CURRENT_LIMIT_SOURCE_50;
    else if (ss_cnt_q < 3 * SS_STEP)
      current_limit_source_step = SSF_CURRENT_LIMIT_SOURCE_75;
    else
      current_limit_source_step = SSF_CURRENT_LIMIT_SOURCE_100;
  end

  // switching sequence with adaptive dead time
  always_comb
  begin
    state_d = state_q;
    if (ov_fault_q && !restart)
      state_d = SSF_OV_HOLD;
    else if (!drive_en)
      state_d = SSF_OFF;
    else
    begin
      case (state_q)
        SSF_OFF:
          state_d = SSF_WAIT_HS_OFF;
        SSF_WAIT_HS_OFF:
          if (sense.phase_low)
            state_d = SSF_LS_ON;
        SSF_LS_ON:
          if (off_cnt_q == 4'h0 && sense.ton_req)
            state_d = SSF_WAIT_LS_OFF;
        SSF_WAIT_LS_OFF:
          if (sense.dl_off)
            state_d = SSF_HS_ON;
        SSF_HS_ON:
          if (sense.ton_done)
            state_d = SSF_WAIT_HS_OFF;
        SSF_OV_HOLD:
          state_d = SSF_OV_HOLD;
        default:
          state_d = SSF_OFF;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_q <= SSF_OFF;
    else
      state_q <= state_d;
  end

  // doubled off-time
  // loaded as the low side turns on, counts the off time down
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      off_cnt_q <= 4'h0;
    else if (state_q != SSF_LS_ON && state_d == SSF_LS_ON)
      off_cnt_q <= first_step ? OFF_DBL - 4'h1 : OFF_NORM - 4'h1;
    else if (off_cnt_q != 4'h0)
      off_cnt_q <= off_cnt_q - 4'h1;
  end

  // gate drive outputs follow the next state so the interlock costs no extra cycle
  // low side held on
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      low_side_drive_o <= 1'b0;
      high_side_drive_o <= 1'b0;
    end
    else
    begin
      low_side_drive_o <= (state_d == SSF_LS_ON) || (state_d == SSF_OV_HOLD);
      high_side_drive_o <= (state_d == SSF_HS_ON);
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      high_side_drive_strong_o <= 1'b0;
    else
      high_side_drive_strong_o <= (state_d == SSF_HS_ON) && (state_q == SSF_HS_ON) && sense.phase_strong;
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      low_side_drive_oe_o <= 1'b0;
      high_side_drive_oe_o <= 1'b0;
    end
    else
    begin
      low_side_drive_oe_o <= drive_en;
      high_side_drive_oe_o <= drive_en;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      current_limit_source_o <= SSF_CURRENT_LIMIT_SOURCE_25;
      sensed_output_level_offset_en_o <= 1'b0;
    end
    else
    begin
      current_limit_source_o <= current_limit_source_step;
      sensed_output_level_offset_en_o <= first_step && drive_en;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      powersave_en_o <= 1'b0;
    else
      powersave_en_o <= sense.en_high && !sense.en_low;
  end

  // power-good release
  // open drain: the pin is pulled low while the enable is high
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      power_good_o <= 1'b0;
      power_good_out_oe_o <= 1'b1;
    end
    else
    begin
      power_good_o <= eval_en && pg_filt && !uv_fault_q && !ov_fault_q;
      power_good_out_oe_o <= !(eval_en && pg_filt && !uv_fault_q && !ov_fault_q);
    end
  end

  // status copies for the system
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      uv_fault_o <= 1'b0;
      ov_fault_o <= 1'b0;
      softstart_done_o <= 1'b0;
    end
    else
    begin
      uv_fault_o <= uv_fault_q;
      ov_fault_o <= ov_fault_q;
      softstart_done_o <= ss_done;
    end
  end
endmodule

// ### rtl/ssf_sync.sv
// Purpose: three-stage synchroniser for the analog comparator levels
// Assumes: raw levels are asynchronous to sys_clk_i
// Notes: a change is accepted once stages two and three agree
`timescale 1ns/1ps
`include "ssf_regs.svh"
module ssf_sync (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [`SSF_NSENSE-1:0] raw_i,
  ssf_sense_if.src sense
);
  import ssf_pkg::*;

  logic [`SSF_NSENSE-1:0] s1_q;
  logic [`SSF_NSENSE-1:0] s2_q;
  logic [`SSF_NSENSE-1:0] s3_q;
  logic [`SSF_NSENSE-1:0] lvl_q;

  // stage one is read by stage two only
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= raw_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept bits where the two later stages agree, hold others
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      lvl_q <= '0;
    else
      lvl_q <= (lvl_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
  end

  // bit order fixed by the core's raw vector
  assign {sense.supply_por, sense.supply_hi, sense.supply_lo, sense.en_high, sense.en_low,
          sense.uv_cmp, sense.ov_cmp, sense.pg_cmp, sense.dl_off, sense.phase_low,
          sense.phase_strong, sense.ton_req, sense.ton_done} = lvl_q;
endmodule

// ### testbench/softstart_fault_sequencer_tb.sv
// Purpose: self-checking bench of the start-up and fault sequencer
// Assumes: 10 MHz clock, inputs changed at rising edges
// Notes: switching cycles are counted at high-side pulse ends
`timescale 1ns/1ps
module softstart_fault_sequencer_tb;
  import ssf_pkg::*;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic por = 1'b0, rise = 1'b0, fall = 1'b0, en_hi = 1'b0, en_lo = 1'b0;
  logic uv = 1'b0, ov = 1'b0, pg = 1'b1, slow = 1'b0;
  logic ls_off, ph_low, ph_strong, on_req, on_done;
  logic hs, hs_st, hs_oe, ls, ls_oe, offs, psave, pg_oe, pg_o, uv_f, ov_f, done;
  ssf_current_limit_source_t limit;
  int fail_count = 0, total_checks = 0, sw_cnt = 0, ls_run = 0, ls_len = 0;

  always #50 sys_clk_i = ~sys_clk_i;
  // switching cycles and low-side on length, for the step checks
  always @(negedge hs) sw_cnt = sw_cnt + 1;
  always @(posedge sys_clk_i)
  begin
    if (ls === 1'b1) ls_run = ls_run + 1;
    else if (ls_run != 0) begin ls_len = ls_run; ls_run = 0; end
  end

  ssf_seq i_dut (.sys_clk_i, .resetn_i, .supply_por_cmp_i(por), .supply_rise_cmp_i(rise),
    .supply_fall_cmp_i(fall), .enable_powersave_pin_high_i(en_hi), .enable_powersave_pin_low_i(en_lo),
    .sensed_output_uv_cmp_i(uv), .sensed_output_ov_cmp_i(ov), .sensed_output_pg_cmp_i(pg),
    .low_side_drive_off_i(ls_off), .phase_node_low_i(ph_low), .phase_node_strong_i(ph_strong),
    .on_request_i(on_req), .on_time_done_i(on_done), .high_side_drive_o(hs), .high_side_drive_strong_o(hs_st),
    .high_side_drive_oe_o(hs_oe), .low_side_drive_o(ls), .low_side_drive_oe_o(ls_oe),
    .current_limit_source_o(limit), .sensed_output_level_offset_en_o(offs), .powersave_en_o(psave),
    .power_good_out_oe_o(pg_oe), .power_good_o(pg_o), .uv_fault_o(uv_f), .ov_fault_o(ov_f),
    .softstart_done_o(done));
  ssf_power_stage i_stage (.sys_clk_i, .resetn_i, .slow_i(slow), .hs_drive_i(hs), .hs_oe_i(hs_oe),
    .ls_drive_i(ls), .ls_oe_i(ls_oe), .low_side_drive_off_o(ls_off), .phase_node_low_o(ph_low),
    .phase_node_strong_o(ph_strong), .on_request_o(on_req), .on_time_done_o(on_done));

  task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin fail_count++; $display("unexpected %s expected %h seen %h", nm, exp, seen); end
  endtask
  task automatic cyc(input int n); repeat (n) @(negedge sys_clk_i); endtask
  task automatic drive(input logic p, r, f, h, l, u, o);
    @(posedge sys_clk_i);
    por <= p; rise <= r; fall <= f; en_hi <= h; en_lo <= l; uv <= u; ov <= o;
  endtask
  // bounded wait for the first gate pulse after a restart
  task automatic first_pulse();
    sw_cnt = 0;
    repeat (3000) begin @(negedge sys_clk_i); if (hs === 1'b1 || ls === 1'b1) break; end
    chk("first pulse low side", {hs, ls}, 4'h1);
  endtask
  task automatic wait_sw(input int n);
    repeat (40000) begin @(negedge sys_clk_i); if (sw_cnt >= n) break; end
  endtask

  task automatic t_reset();
    cyc(3);
    chk("reset drives", {hs, ls, hs_oe, ls_oe}, 4'h0);
    chk("reset limit", {pg_oe, limit}, {2'h0, 1'b1, SSF_CURRENT_LIMIT_SOURCE_25});
    // release on a rising edge, like every other input change
    @(posedge sys_clk_i);
    resetn_i <= 1'b1;
  endtask
  task automatic t_start();
    drive(1, 0, 1, 1, 0, 0, 0);
    cyc(40);
    chk("inhibit below rise", {hs, ls, ls_oe}, 4'h0);
    drive(1, 1, 1, 1, 0, 0, 0);
    first_pulse();
    chk("power save", psave, 4'h1);
  endtask
  task automatic t_softstart();
    wait_sw(50);
    chk("step one", {offs, pg_o, limit}, {2'h2, SSF_CURRENT_LIMIT_SOURCE_25});
    chk("doubled off", ls_len >= 8, 4'h1);
    wait_sw(160);
    chk("step two", {offs, limit}, {1'b0, SSF_CURRENT_LIMIT_SOURCE_50});
    chk("normal off", ls_len < 8, 4'h1);
    wait_sw(270);
    chk("step three", limit, SSF_CURRENT_LIMIT_SOURCE_75);
    wait_sw(380);
    chk("step four", {done, limit}, {1'b0, SSF_CURRENT_LIMIT_SOURCE_100});
    wait_sw(445);
    chk("held full", {done, limit}, {1'b1, SSF_CURRENT_LIMIT_SOURCE_100});
    cyc(80);
    chk("power good", {pg_o, pg_oe}, 4'h2);
  endtask
  task automatic t_uv();
    drive(1, 1, 1, 1, 0, 1, 0);
    cyc(30);
    drive(1, 1, 1, 1, 0, 0, 0);
    cyc(20);
    chk("short dip ignored", uv_f, 4'h0);
    drive(1, 1, 1, 1, 0, 1, 0);
    cyc(80);
    drive(1, 1, 1, 0, 0, 0, 0);
    cyc(20);
    chk("uv latched", {uv_f, hs_oe, ls_oe}, 4'h4);
    drive(1, 1, 1, 0, 1, 0, 0);
    cyc(30);
    chk("pin low off", {hs_oe, ls_oe}, 4'h0);
    @(posedge sys_clk_i);
    slow <= 1'b1;
    drive(1, 1, 1, 0, 0, 0, 0);
    first_pulse();
    chk("restart clean", {uv_f, done, psave}, 4'h0);
  endtask
  task automatic t_ov();
    drive(1, 1, 1, 0, 0, 0, 1);
    cyc(80);
    chk("ov clamp", {ov_f, ls, hs}, 4'h6);
    drive(1, 0, 1, 0, 0, 0, 0);
    cyc(30);
    chk("ov held in band", {ov_f, ls, ls_oe}, 4'h7);
    drive(1, 0, 0, 0, 0, 0, 0);
    cyc(30);
    chk("lockout tristate", {hs, ls, hs_oe, ls_oe}, 4'h0);
    drive(1, 1, 1, 0, 0, 0, 0);
    first_pulse();
    chk("ov cleared", ov_f, 4'h0);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    t_reset();
    t_start();
    t_softstart();
    t_uv();
    t_ov();
    finish_test();
  end
  // watchdog well beyond two soft-start runs
  initial
  begin
    repeat (90000) @(posedge sys_clk_i);
    fail_count++;
    finish_test();
  end
endmodule

// ### testbench/ssf_power_stage.sv
// Purpose: behavioural power switches and on-time source facing the sequencer
// Assumes: gates and phase node settle in whole clock cycles
// Notes: slow_i stretches the low-side gate discharge to stress the interlock
`timescale 1ns/1ps
module ssf_power_stage (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic slow_i,
  input wire logic hs_drive_i,
  input wire logic hs_oe_i,
  input wire logic ls_drive_i,
  input wire logic ls_oe_i,
  output logic low_side_drive_off_o,
  output logic phase_node_low_o,
  output logic phase_node_strong_o,
  output logic on_request_o,
  output logic on_time_done_o
);
  logic [2:0] ls_q;
  logic [1:0] hs_q;
  logic [1:0] ton_q;
  // a released gate is pulled off, so oe low counts as off
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ls_q <= 3'h0;
      hs_q <= 2'h0;
      ton_q <= 2'h0;
    end
    else
    begin
      ls_q <= {ls_q[1:0], ls_drive_i & ls_oe_i};
      hs_q <= {hs_q[0], hs_drive_i & hs_oe_i};
      ton_q <= (hs_drive_i && ton_q != 2'h3) ? ton_q + 2'h1 : (hs_drive_i ? ton_q : 2'h0);
    end
  end
  assign low_side_drive_off_o = slow_i ? ~|ls_q : ~ls_q[0];
  assign phase_node_low_o = ~|hs_q;
  assign phase_node_strong_o = hs_q[1];
  // asks for a pulse whenever the high side rests
  assign on_request_o = ~hs_q[0];
  assign on_time_done_o = (ton_q == 2'h3);
endmodule

// ### testbench/ssf_seq_assertions.sv
// Purpose: port-level checks of the start-up and fault sequencer
// Assumes: single clock, reset asynchronous and active low
// Notes: bound to the sequencer; loose only where synchroniser latency applies
`timescale 1ns/1ps
module ssf_seq_assertions
  import ssf_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic high_side_drive_o,
  input wire logic high_side_drive_strong_o,
  input wire logic low_side_drive_o,
  input wire logic high_side_drive_oe_o,
  input wire logic low_side_drive_oe_o,
  input wire ssf_pkg::ssf_current_limit_source_t current_limit_source_o,
  input wire logic sensed_output_level_offset_en_o,
  input wire logic power_good_o,
  input wire logic uv_fault_o,
  input wire logic ov_fault_o,
  input wire logic softstart_done_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // pulse end, then the off one-shot window
  sequence pulse_end_s;
    $fell(high_side_drive_o);
  endsequence
  sequence off_window_s;
    !high_side_drive_o [*4];
  endsequence
  sequence ov_clamp_s;
    low_side_drive_o && low_side_drive_oe_o && !high_side_drive_o;
  endsequence

  no_shoot_a: assert property (!(high_side_drive_o && low_side_drive_o))
    else $error("both gate drives on together");
  off_time_a: assert property (pulse_end_s |=> off_window_s)
    else $error("off time shorter than four cycles");
  strong_late_a: assert property ($rose(high_side_drive_strong_o) |-> $past(high_side_drive_o))
    else $error("strong pull-up without a weak cycle first");
  strong_only_a: assert property (high_side_drive_strong_o |-> high_side_drive_o)
    else $error("strong pull-up while high side off");
  pg_gate_a: assert property ($rose(power_good_o) |-> softstart_done_o)
    else $error("power good released during soft-start");
  uv_gate_a: assert property ($rose(uv_fault_o) |-> softstart_done_o)
    else $error("undervoltage latched during soft-start");
  ss_full_a: assert property (softstart_done_o |-> current_limit_source_o == SSF_CURRENT_LIMIT_SOURCE_100)
    else $error("limit not full scale after soft-start");
  offset_step_a: assert property (sensed_output_level_offset_en_o |-> current_limit_source_o == SSF_CURRENT_LIMIT_SOURCE_25)
    else $error("offset active outside the first step");
  uv_tristate_a: assert property (uv_fault_o |=> !high_side_drive_oe_o && !low_side_drive_oe_o)
    else $error("drives not released under undervoltage");
  ov_hold_a: assert property ($rose(ov_fault_o) |-> ##[0:2] ov_clamp_s)
    else $error("low side not clamped on overvoltage");
endmodule

bind ssf_seq ssf_seq_assertions i_chk (.sys_clk_i, .resetn_i, .high_side_drive_o,
  .high_side_drive_strong_o, .low_side_drive_o, .high_side_drive_oe_o, .low_side_drive_oe_o,
  .current_limit_source_o, .sensed_output_level_offset_en_o, .power_good_o, .uv_fault_o, .ov_fault_o,
  .softstart_done_o);
